// >>> cmb_pkg.sv
// Shared constants and carrier types of the CAN message-buffer control block.
// Assumes a 16-bit register port and a protocol engine on the same clock.
package cmb_pkg;

    // ------------------------------------------------------------
    // Register word indices on the register port
    // ------------------------------------------------------------
    localparam int CMB_AW = 4;                              // Address width.
    localparam logic [3:0] CMB_ADDR_MASK_EID = 4'h0;        // Extended-id acceptance mask.
    localparam logic [3:0] CMB_ADDR_MASK_STD = 4'h1;        // Standard-id acceptance mask.
    localparam logic [3:0] CMB_ADDR_FUL_LO = 4'h2;          // Full flags, buffers 15..0.
    localparam logic [3:0] CMB_ADDR_FUL_HI = 4'h3;          // Full flags, buffers 31..16.
    localparam logic [3:0] CMB_ADDR_OVF_LO = 4'h4;          // Overrun flags, buffers 15..0.
    localparam logic [3:0] CMB_ADDR_OVF_HI = 4'h5;          // Overrun flags, buffers 31..16.
    localparam logic [3:0] CMB_ADDR_CON0 = 4'h6;            // First pair control word.

    // ------------------------------------------------------------
    // Sizes, field positions and reset values
    // ------------------------------------------------------------
    localparam int CMB_WORD_W = 16;                         // Register width.
    localparam int CMB_NUM_BUF = 32;                        // Receive buffers.
    localparam int CMB_NUM_TX = 8;                          // Buffers with a control byte.
    localparam int CMB_NUM_CON = 4;                         // Pair control words.
    localparam int CMB_SID_W = 11;                          // Standard identifier width.
    localparam int CMB_EID_W = 18;                          // Extended identifier width.
    localparam int CMB_EIDW_W = 12;                         // Id bits held in the ext word.
    localparam int CMB_EIDW_SRC = 6;                        // Lowest id bit in the ext word.
    localparam int CMB_MASKE_W = 16;                        // Ext mask bits in mask word.
    localparam int CMB_FHIT_W = 5;                          // Filter hit code width.
    localparam int CMB_SID_LSB = 2;                         // Std id position in its word.
    localparam int CMB_SRR_BIT = 1;                         // Remote request position.
    localparam int CMB_IDE_BIT = 0;                         // Frame format position.
    localparam int CMB_EID_LSB = 0;                         // Ext id position in its word.
    localparam int CMB_FHIT_LSB = 8;                        // Filter hit code position.
    localparam int CMB_MSK_SID_LSB = 5;                     // Std id bits in std mask.
    localparam int CMB_MSK_EIDH_LSB = 0;                    // Ext id bits 17:16 in std mask.
    localparam logic [15:0] CMB_REG_RESET = 16'h0000;       // Register reset value.

    // Control byte of one buffer; the packed order is the register layout.
    typedef struct packed {
        logic dir;                                          // One means transmit buffer.
        logic aborted;                                      // Last send was aborted.
        logic arb_lost;                                     // Arbitration was lost.
        logic tx_err;                                       // Bus error while sending.
        logic req;                                          // Send request.
        logic rtr_en;                                       // Auto-answer remote frames.
        logic [1:0] pri;                                    // Transmit priority.
    } cmb_bctl_t;

    localparam cmb_bctl_t CMB_BCTL_RESET = 8'h00;

    // State of one buffer control slice.
    typedef struct packed {
        cmb_bctl_t ctrl;
        logic abort_req;
    } cmb_bst_t;

    // Received message handed over by the protocol engine.
    typedef struct packed {
        logic valid;
        logic [4:0] buf_idx;
        logic [4:0] filter;
        logic [10:0] standard_identifier;
        logic [17:0] extended_identifier;
        logic srr;
        logic ide;
    } cmb_rx_evt_t;

    // Transmit-side events for one buffer.
    typedef struct packed {
        logic ok;
        logic aborted;
        logic arb_lost;
        logic bus_err;
        logic remote;
        logic [2:0] buf_idx;
    } cmb_tx_evt_t;

    // Write of one buffer's words into DMA memory.
    typedef struct packed {
        logic valid;
        logic [4:0] buf_idx;
        logic [15:0] sid_word;
        logic [15:0] eid_word;
        logic [15:0] stat_word;
    } cmb_dma_wr_t;

    // Identifier pair to test against the acceptance mask.
    typedef struct packed {
        logic [10:0] msg_sid;
        logic [17:0] msg_eid;
        logic [10:0] flt_sid;
        logic [17:0] flt_eid;
    } cmb_flt_t;

endpackage

// >>> cmb_buf_ctrl.sv
// Control byte of one message buffer: direction, request and send status.
// Assumes byte writes and engine events arrive on the same clock.
`timescale 1ns/1ps

module cmb_buf_ctrl
    import cmb_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_wr,
    input wire cmb_bctl_t i_wdata,
    input wire logic i_tx_ok,
    input wire logic i_tx_aborted,
    input wire logic i_arb_lost,
    input wire logic i_bus_err,
    input wire logic i_remote,
    output cmb_bctl_t o_ctrl,
    output logic o_abort_req
);

    cmb_bst_t st_r;     // Whole state of the slice.
    cmb_bst_t st_nxt;   // Its next value.
    logic set_req;      // A new send request this cycle.

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Hardware sets are applied last so that they win over clears.
    always_comb begin
        st_nxt = st_r;
        st_nxt.abort_req = 1'b0;
        set_req = 1'b0;
        if (i_wr) begin
            st_nxt.ctrl.dir = i_wdata.dir;
            st_nxt.ctrl.rtr_en = i_wdata.rtr_en;
            st_nxt.ctrl.pri = i_wdata.pri;
            if (i_wdata.req) begin
                set_req = 1'b1;
            end else if (st_r.ctrl.req) begin
                st_nxt.ctrl.req = 1'b0;
                st_nxt.abort_req = 1'b1;
            end
        end
        // Remote frames only restart a buffer set up to answer them.
        if (i_remote && st_r.ctrl.rtr_en && st_r.ctrl.dir) begin
            set_req = 1'b1;
        end
        if (i_tx_ok || i_tx_aborted) begin
            st_nxt.ctrl.req = 1'b0;
        end
        if (set_req) begin
            st_nxt.ctrl.req = 1'b1;
            st_nxt.ctrl.aborted = 1'b0;
            st_nxt.ctrl.arb_lost = 1'b0;
            st_nxt.ctrl.tx_err = 1'b0;
        end
        if (i_tx_ok) begin
            st_nxt.ctrl.aborted = 1'b0;
        end
        if (i_tx_aborted) begin
            st_nxt.ctrl.aborted = 1'b1;
        end
        if (i_arb_lost) begin
            st_nxt.ctrl.arb_lost = 1'b1;
        end
        if (i_bus_err) begin
            st_nxt.ctrl.tx_err = 1'b1;
        end
    end

    // Synchronous reset; a low clock enable freezes the slice.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            st_r <= '{ctrl: CMB_BCTL_RESET, abort_req: 1'b0};
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_ctrl = st_r.ctrl;
    assign o_abort_req = st_r.abort_req;

    a_req_clr_flags: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_wr && i_wdata.req && !i_tx_aborted && !i_arb_lost && !i_bus_err
        |=> o_ctrl.req && !o_ctrl.aborted && !o_ctrl.arb_lost && !o_ctrl.tx_err)
        else $error("send request did not clear status flags");

    a_abort_on_clr: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_wr && !i_wdata.req && o_ctrl.req && !i_remote
        |=> o_abort_req && !o_ctrl.req ##1 (!o_abort_req || !$past(i_ce)))
        else $error("clearing the request gave no single abort pulse");

    a_ok_ends_req: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_tx_ok && !i_tx_aborted && !i_wr && !(i_remote && o_ctrl.rtr_en && o_ctrl.dir)
        |=> !o_ctrl.req && !o_ctrl.aborted)
        else $error("successful send left the request set");

    a_remote_req: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_remote && o_ctrl.dir && !i_wr
        |=> o_ctrl.req == $past(o_ctrl.rtr_en || o_ctrl.req) || $past(i_tx_ok || i_tx_aborted))
        else $error("remote frame handling of request is wrong");

endmodule

// >>> cmb_msgbuf_ctrl.sv
// Message-buffer control and status of a CAN controller: masks, flags, control.
// Assumes a same-clock protocol engine and a register master that never waits.
`timescale 1ns/1ps

import cmb_pkg::*;

// Summary of operation
// - Ext mask one compares bit, zero ignores
// - Receive sets full flag, software clears
// - Receive into full buffer sets overrun
// - Direction one transmits, zero receives
// - Aborted flag shows last send aborted
// - Arbitration-lost flag set on lost arbitration
// - Error flag set on bus error
// - Request starts send, cleared on success
// - Clearing pending request asks for abort
// - Auto-remote sets request on remote frame
// - Two-bit priority, three highest, zero lowest
// - New request clears the three status flags
// - Control word: odd buffer high, even low
// - Std id word bits 12..2, top zero
// - Bit one is substitute remote request
// - Bit zero selects extended frame format
// - Ext id word holds id 17..6, top zero
// - Id and status words live in DMA memory
// - Status word records five-bit filter hit
// - Std mask one compares bit, zero ignores
module cmb_msgbuf_ctrl
    import cmb_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire cmb_rx_evt_t i_rx_evt,
    input wire cmb_tx_evt_t i_tx_evt,
    input wire cmb_flt_t i_flt,
    output logic o_filter_match,
    output cmb_dma_wr_t o_dma,
    output logic o_tx_valid,
    output logic [2:0] o_tx_sel,
    output logic [7:0] o_abort_req
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    // All flip-flops of this level; buffer control bytes sit in the slices.
    typedef struct packed {
        logic [15:0] mask_eid;      // Extended-id mask, bits 15..0.
        logic [15:0] mask_std;      // Standard-id mask and ext bits 17:16.
        logic [31:0] full;          // Receive-full flags.
        logic [31:0] ovf;           // Receive-overrun flags.
        logic [15:0] rdata;         // Read data, valid one cycle.
        cmb_dma_wr_t dma;           // Pending DMA memory write.
        logic match;                // Acceptance result.
        logic tx_valid;             // A transmit buffer is pending.
        logic [2:0] tx_sel;         // The buffer to send next.
    } cmb_top_st_t;

    cmb_top_st_t st_r;              // Registered state.
    cmb_top_st_t st_nxt;            // Next state.

    cmb_bctl_t ctrl [CMB_NUM_TX];   // Control bytes of the slices.
    logic [7:0] abort_req;          // Abort pulses of the slices.
    logic [15:0] rd_val;            // Read mux output.
    logic [17:0] eid_cmp_mask;      // Joined extended mask.
    logic [10:0] sid_cmp_mask;      // Standard mask bits.
    logic best_found;               // Search found a pending buffer.
    logic [1:0] best_pri;           // Priority of the best so far.
    logic [2:0] best_idx;           // Index of the best so far.

    // ------------------------------------------------------------
    // Buffer control slices
    // ------------------------------------------------------------

    // Each pair word writes two slices: the even buffer owns the
    // low byte and the odd buffer the high byte.
    for (genvar g = 0; g < CMB_NUM_TX; g++) begin : g_buf
        logic wr_hit;       // This buffer's byte is written.
        logic ev_hit;       // Engine event names this buffer.
        assign wr_hit = i_wr && (i_addr == CMB_ADDR_CON0 + 4'(g / 2));
        assign ev_hit = (i_tx_evt.buf_idx == 3'(g));

        cmb_buf_ctrl u_ctrl (
            .i_mclk(i_mclk),
            .i_reset_n(i_reset_n),
            .i_ce(i_ce),
            .i_wr(wr_hit),
            .i_wdata(i_wdata[(g % 2) * 8 +: 8]),
            .i_tx_ok(ev_hit && i_tx_evt.ok),
            .i_tx_aborted(ev_hit && i_tx_evt.aborted),
            .i_arb_lost(ev_hit && i_tx_evt.arb_lost),
            .i_bus_err(ev_hit && i_tx_evt.bus_err),
            .i_remote(ev_hit && i_tx_evt.remote),
            .o_ctrl(ctrl[g]),
            .o_abort_req(abort_req[g])
        );
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------

    // Unmapped addresses read as zero.
    always_comb begin
        rd_val = CMB_REG_RESET;
        case (i_addr)
            CMB_ADDR_MASK_EID: rd_val = st_r.mask_eid;
            CMB_ADDR_MASK_STD: rd_val = st_r.mask_std;
            CMB_ADDR_FUL_LO: rd_val = st_r.full[0 +: CMB_WORD_W];
            CMB_ADDR_FUL_HI: rd_val = st_r.full[CMB_WORD_W +: CMB_WORD_W];
            CMB_ADDR_OVF_LO: rd_val = st_r.ovf[0 +: CMB_WORD_W];
            CMB_ADDR_OVF_HI: rd_val = st_r.ovf[CMB_WORD_W +: CMB_WORD_W];
            default: begin
                for (int k = 0; k < CMB_NUM_CON; k++) begin
                    if (i_addr == CMB_ADDR_CON0 + 4'(k)) begin
                        rd_val = {ctrl[2 * k + 1], ctrl[2 * k]};
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Transmit selection
    // ------------------------------------------------------------

    // Highest priority field wins; on a tie the higher buffer
    // number wins because the search walks upward with >=.
    always_comb begin
        best_found = 1'b0;
        best_pri = 2'h0;
        best_idx = 3'h0;
        for (int i = 0; i < CMB_NUM_TX; i++) begin
            if (ctrl[i].dir && ctrl[i].req) begin
                if (!best_found || ctrl[i].pri >= best_pri) begin
                    best_found = 1'b1;
                    best_pri = ctrl[i].pri;
                    best_idx = 3'(i);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Acceptance mask
    // ------------------------------------------------------------

    // Mask ones take part in the comparison, zeros are don't-care.
    assign eid_cmp_mask = {st_r.mask_std[CMB_MSK_EIDH_LSB +: 2], st_r.mask_eid};
    assign sid_cmp_mask = st_r.mask_std[CMB_MSK_SID_LSB +: CMB_SID_W];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Software clears go first and hardware sets after them, so
    // an event in the clearing cycle is never lost.
    always_comb begin
        st_nxt = st_r;
        st_nxt.dma.valid = 1'b0;
        // Read data stand only in the cycle after the strobe.
        st_nxt.rdata = i_rd ? rd_val : CMB_REG_RESET;
        st_nxt.match = (((i_flt.msg_sid ^ i_flt.flt_sid) & sid_cmp_mask) == '0)
            && (((i_flt.msg_eid ^ i_flt.flt_eid) & eid_cmp_mask) == '0);
        st_nxt.tx_valid = best_found;
        st_nxt.tx_sel = best_idx;

        if (i_wr) begin
            case (i_addr)
                CMB_ADDR_MASK_EID: st_nxt.mask_eid = i_wdata;
                CMB_ADDR_MASK_STD: st_nxt.mask_std = i_wdata;
                CMB_ADDR_FUL_LO: st_nxt.full[0 +: CMB_WORD_W] &= i_wdata;
                CMB_ADDR_FUL_HI: st_nxt.full[CMB_WORD_W +: CMB_WORD_W] &= i_wdata;
                CMB_ADDR_OVF_LO: st_nxt.ovf[0 +: CMB_WORD_W] &= i_wdata;
                CMB_ADDR_OVF_HI: st_nxt.ovf[CMB_WORD_W +: CMB_WORD_W] &= i_wdata;
                default: begin
                    // Control words are held in the slices.
                end
            endcase
        end

        if (i_rx_evt.valid) begin
            if (st_r.full[i_rx_evt.buf_idx]) begin
                // The buffer still holds an unread message; it is
                // kept and the new one is dropped.
                st_nxt.ovf[i_rx_evt.buf_idx] = 1'b1;
            end else begin
                st_nxt.full[i_rx_evt.buf_idx] = 1'b1;
                // The words go out to DMA memory, not to registers.
                st_nxt.dma.valid = 1'b1;
                st_nxt.dma.buf_idx = i_rx_evt.buf_idx;
                st_nxt.dma.sid_word = '0;
                st_nxt.dma.sid_word[CMB_SID_LSB +: CMB_SID_W] = i_rx_evt.standard_identifier;
                st_nxt.dma.sid_word[CMB_SRR_BIT] = i_rx_evt.srr;
                st_nxt.dma.sid_word[CMB_IDE_BIT] = i_rx_evt.ide;
                st_nxt.dma.eid_word = '0;
                st_nxt.dma.eid_word[CMB_EID_LSB +: CMB_EIDW_W] =
                    i_rx_evt.extended_identifier[CMB_EIDW_SRC +: CMB_EIDW_W];
                st_nxt.dma.stat_word = '0;
                st_nxt.dma.stat_word[CMB_FHIT_LSB +: CMB_FHIT_W] = i_rx_evt.filter;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Synchronous reset; a low clock enable freezes everything.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_rdata = st_r.rdata;
    assign o_filter_match = st_r.match;
    assign o_dma = st_r.dma;
    assign o_tx_valid = st_r.tx_valid;
    assign o_tx_sel = st_r.tx_sel;
    assign o_abort_req = abort_req;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------

    a_rx_sets_full: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_rx_evt.valid && !st_r.full[i_rx_evt.buf_idx]
        |=> st_r.full[$past(i_rx_evt.buf_idx)] && !st_r.ovf[$past(i_rx_evt.buf_idx)]
            || $past(st_r.ovf[i_rx_evt.buf_idx]))
        else $error("receive did not mark the buffer full");

    a_rx_overrun: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_rx_evt.valid && st_r.full[i_rx_evt.buf_idx]
        |=> st_r.ovf[$past(i_rx_evt.buf_idx)] && !o_dma.valid)
        else $error("write to a full buffer did not flag overrun");

    a_wc_one_keeps: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_wr && i_addr == CMB_ADDR_FUL_LO && i_wdata == 16'hffff
        |=> st_r.full[0 +: CMB_WORD_W] == $past(st_r.full[0 +: CMB_WORD_W])
            || $past(i_rx_evt.valid))
        else $error("writing one changed a full flag");

    a_wc_zero_clears: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_wr && i_addr == CMB_ADDR_OVF_HI && i_wdata == 16'h0000 && !i_rx_evt.valid
        |=> st_r.ovf[CMB_WORD_W +: CMB_WORD_W] == 16'h0000)
        else $error("writing zero did not clear overrun flags");

    a_dma_status: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_rx_evt.valid && !st_r.full[i_rx_evt.buf_idx]
        |=> o_dma.valid && o_dma.stat_word == {3'h0, $past(i_rx_evt.filter), 8'h00})
        else $error("status word does not hold the filter hit");

    a_sid_word_fmt: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_rx_evt.valid && !st_r.full[i_rx_evt.buf_idx]
        |=> o_dma.sid_word == {3'h0, $past(i_rx_evt.standard_identifier), $past(i_rx_evt.srr), $past(i_rx_evt.ide)})
        else $error("standard id word layout is wrong");

    a_eid_word_fmt: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && i_rx_evt.valid && !st_r.full[i_rx_evt.buf_idx]
        |=> o_dma.eid_word == {4'h0, $past(i_rx_evt.extended_identifier[17:6])})
        else $error("extended id word top bits not zero");

    a_mask_dontcare: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_reset_n && i_ce && st_r.mask_eid == 16'h0000 && st_r.mask_std == 16'h0000 |=> o_filter_match)
        else $error("all-zero mask did not accept");

    a_mask_compare: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && st_r.mask_std[CMB_MSK_SID_LSB] && (i_flt.msg_sid[0] != i_flt.flt_sid[0])
        |=> !o_filter_match)
        else $error("masked-in standard id bit was ignored");

    a_tx_pick: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_ce && best_found && !i_wr |=> o_tx_valid && ctrl[o_tx_sel].dir
            && ctrl[o_tx_sel].pri == $past(best_pri))
        else $error("transmit pick is not the best pending buffer");

endmodule

// >>> cmb_engine_model.sv
// Protocol engine stand-in that answers transmit requests and aborts.
// Assumes the same clock as the control block; receive and injected transmit events come from the bench.
`timescale 1ns/1ps
module cmb_engine_model
    import cmb_pkg::*;
#(
    parameter int DELAY = 3
)
(
    input wire logic i_mclk,
    input wire logic i_tx_valid,
    input wire logic [2:0] i_tx_sel,
    input wire logic [7:0] i_abort_req,
    input wire cmb_rx_evt_t i_rx,
    input wire cmb_tx_evt_t i_tx,
    output cmb_rx_evt_t o_rx = '0,
    output cmb_tx_evt_t o_tx = '0
);
    int wait_n = 0;
    // A slow bus needs DELAY cycles of pending request before a frame completes.
    always @(posedge i_mclk) begin
        o_rx <= i_rx;
        o_tx <= i_tx;
        wait_n <= i_tx_valid ? wait_n + 1 : 0;
        for (int i = 0; i < 8; i++) begin
            if (i_abort_req[i]) begin
                o_tx.aborted <= 1'b1;
                o_tx.buf_idx <= i[2:0];
            end
        end
        if (i_abort_req == 8'h00 && wait_n == DELAY) begin
            o_tx.ok <= 1'b1;
            o_tx.buf_idx <= i_tx_sel;
            wait_n <= 0;
        end
    end
endmodule

// >>> cmb_msgbuf_ctrl_bench.sv
// Self-checking bench of the message-buffer control block.
// Assumes the engine model answers every pending transmit within a few cycles.
`timescale 1ns/1ps
module cmb_msgbuf_ctrl_bench
    import cmb_pkg::*;
;
    logic i_mclk = 0, i_reset_n = 0, wr = 0, rd = 0, ce = 1, o_filter_match, o_tx_valid;
    logic [3:0] addr = '0;
    logic [15:0] wdata = '0, o_rdata;
    logic [7:0] o_abort_req;
    logic [2:0] o_tx_sel;
    cmb_rx_evt_t rx_cmd = '0, rx_evt;
    cmb_tx_evt_t tx_cmd = '0, tx_evt;
    cmb_flt_t flt = '0;
    cmb_dma_wr_t o_dma;
    int failures = 0, comparisons = 0;
    always #2.5 i_mclk = ~i_mclk;
    cmb_msgbuf_ctrl i_cmb_msgbuf_ctrl (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(o_rdata), .i_rx_evt(rx_evt), .i_tx_evt(tx_evt),
        .i_flt(flt), .o_filter_match(o_filter_match), .o_dma(o_dma), .o_tx_valid(o_tx_valid),
        .o_tx_sel(o_tx_sel), .o_abort_req(o_abort_req));
    cmb_engine_model i_cmb_engine_model (.i_mclk(i_mclk), .i_tx_valid(o_tx_valid), .i_tx_sel(o_tx_sel),
        .i_abort_req(o_abort_req), .i_rx(rx_cmd), .i_tx(tx_cmd), .o_rx(rx_evt), .o_tx(tx_evt));
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge i_mclk) wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just then.
    task rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_mclk) {addr, rd} <= {a, 1'b1};
        @(posedge i_mclk) rd <= 1'b0;
        #1 chk(o_rdata, exp, "rdata");
    endtask
    task rx(input logic [4:0] b);
        @(posedge i_mclk) rx_cmd <= {1'b1, b, 5'd9, 11'h5a5, 18'h3c0ff, 2'b10};
        @(posedge i_mclk) rx_cmd <= '0;
        @(posedge i_mclk) #1;
    endtask
    // Injects one engine event; the control byte has it one cycle after the model passes it on.
    task tx_ev(input cmb_tx_evt_t e);
        @(posedge i_mclk) tx_cmd <= e;
        @(posedge i_mclk) tx_cmd <= '0;
        @(posedge i_mclk) #1;
    endtask
    task complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_mclk);
        failures++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        for (int a = 2; a < 10; a++) rd_chk(a[3:0], 16'h0000);
        rd_chk(4'hf, 16'h0000);
        bus_wr(4'h0, 16'h00ff);
        @(posedge i_mclk) flt <= {11'h0, 18'h00100, 11'h0, 18'h0};
        repeat (2) @(posedge i_mclk);
        #1 chk(o_filter_match, 1, "masked out");
        @(posedge i_mclk) flt <= {11'h0, 18'h00001, 11'h0, 18'h0};
        repeat (2) @(posedge i_mclk);
        #1 chk(o_filter_match, 0, "masked in");
        rx(5'd5);
        chk({o_dma.valid, o_dma.buf_idx}, 16'h0025, "dma buf");
        chk(o_dma.sid_word, 16'h1696, "sid word");
        chk(o_dma.eid_word, 16'h0f03, "eid word");
        chk(o_dma.stat_word, 16'h0900, "stat word");
        rd_chk(4'h2, 16'h0020);
        rx(5'd5);
        chk(o_dma.valid, 0, "dropped");
        rd_chk(4'h4, 16'h0020);
        bus_wr(4'h2, 16'hffdf);
        bus_wr(4'h4, 16'h0000);
        rd_chk(4'h2, 16'h0000);
        rd_chk(4'h4, 16'h0000);
        bus_wr(4'h6, 16'h8b89);
        repeat (2) @(posedge i_mclk);
        #1 chk(o_tx_sel, 1, "tx sel");
        chk(o_tx_valid, 1, "tx valid");
        repeat (20) @(posedge i_mclk);
        rd_chk(4'h6, 16'h8381);
        bus_wr(4'h7, 16'h0008);
        bus_wr(4'h7, 16'h0000);
        #1 chk(o_abort_req, 16'h0004, "abort");
        repeat (3) @(posedge i_mclk);
        rd_chk(4'h7, 16'h0040);
        bus_wr(4'h7, 16'h8408);
        rd_chk(4'h7, 16'h8408);
        tx_ev(8'h32);
        rd_chk(4'h7, 16'h8438);
        tx_ev(8'h0b);
        repeat (2) @(posedge i_mclk);
        #1 chk(o_tx_valid, 1, "remote valid");
        chk(o_tx_sel, 3, "remote sel");
        repeat (8) @(posedge i_mclk);
        #1 chk(o_tx_valid, 0, "remote sent");
        @(posedge i_mclk) ce <= 1'b0;
        bus_wr(4'h0, 16'h1234);
        @(posedge i_mclk) ce <= 1'b1;
        rd_chk(4'h0, 16'h00ff);
        complete_run;
    end
endmodule
